// *** rtl/ddsl_map.svh ***
// Constants of the dual converter serial loader: field positions, widths, reset values.
// Assumes inclusion by bare name from the rtl/ files.
`ifndef DDSL_MAP_SVH
`define DDSL_MAP_SVH
// ----------------------------------------
// Word layout, bit 15 arrives first
// ----------------------------------------
`define DDSL_WORD_W 16
`define DDSL_CODE_W 8
`define DDSL_BIT_SPARE_FIRST 15
`define DDSL_BIT_SPARE_SECOND 14
`define DDSL_BIT_SPARE_THIRD 13
`define DDSL_BIT_SHUTDOWN_B 12
`define DDSL_BIT_SHUTDOWN_A 11
`define DDSL_BIT_SPARE_FOURTH 10
`define DDSL_BIT_LOAD_B 9
`define DDSL_BIT_LOAD_A 8
`define DDSL_CODE_MSB 7
`define DDSL_CODE_LSB 0
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define DDSL_WORD_RESET 16'h0000
`define DDSL_CODE_RESET 8'h00
`define DDSL_SETTLE_US 10
`define DDSL_CLK_MHZ 250
`define DDSL_SETTLE_CYCLES (`DDSL_SETTLE_US * `DDSL_CLK_MHZ)
`endif

// *** rtl/ddsl_pkg.sv ***
// Types shared by the dual converter serial loader.
// Assumes ddsl_map.svh is on the include path.
`include "ddsl_map.svh"
package ddsl_pkg;
	typedef logic [`DDSL_WORD_W-1:0] ddsl_word_type;
	typedef logic [`DDSL_CODE_W-1:0] ddsl_code_type;
	typedef enum logic [1:0] {DDSL_OUT_OFF, DDSL_OUT_SETTLING, DDSL_OUT_ON} ddsl_out_state_type;
endpackage : ddsl_pkg

// *** rtl/ddsl_sync.sv ***
// Two flip-flop level synchroniser.
// Assumes an asynchronous input and a free-running destination clock.
`timescale 1ns/1ps
module ddsl_sync
	import ddsl_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			meta_reg <= RESET_VAL;
			sync_o <= RESET_VAL;
		end
		else
		begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule : ddsl_sync

// *** rtl/ddsl_shifter.sv ***
// Link-side shift register of the dual converter loader, on the serial clock.
// Assumes the serial clock may also run with select high, where it is ignored; a toggle flag flips on every shifted bit.
`timescale 1ns/1ps
`include "ddsl_map.svh"
module ddsl_shifter
	import ddsl_pkg::*;
(
	input wire logic sclk_i,
	input wire logic select_n_i,
	input wire logic din_i,
	output ddsl_word_type shift_o,
	output logic edge_seen_o
);
	ddsl_word_type shift_reg = `DDSL_WORD_RESET;
	logic edge_seen_reg = 1'b0;
	// ----------------------------------------
	// Shifting on rising serial clock
	// ----------------------------------------
	assign shift_o = shift_reg;
	assign edge_seen_o = edge_seen_reg;
	always_ff @(posedge sclk_i)
	begin
		if (!select_n_i)
		begin
			shift_reg <= {shift_reg[`DDSL_WORD_W-2:0], din_i};
			edge_seen_reg <= ~edge_seen_reg;
		end
	end
endmodule : ddsl_shifter

// *** rtl/ddsl_loader.sv ***
// Dual converter serial loader: three-wire link, control byte execution, output codes.
// Assumes select, data and serial clock come from a host; mclk_i runs free at 250 MHz.
// Overview of operation
// - Bits enter the 16-bit shift register only while the active-low select is low.
// - The command in the shift register is executed after select rises, once the synchronised select has stayed high for five clock cycles.
// - Serial data is sampled and the register advances on each rising serial clock edge while select is low.
// - A write may be split into segments while select stays low, losing no bits.
// - Execution updates the loaded stored codes and both shutdown states together; both outputs follow one cycle later.
// - One command carries one shared 8-bit code for whichever channels it loads.
// - A channel in shutdown shows zero while its stored code is kept.
// - Leaving shutdown restores the stored code at once and flags settling for SETTLE_CYCLES - 1 clock cycles.
// - In shutdown the reference input is disconnected from the converter load.
// - Wire order is three spares, shutdown B, shutdown A, spare, load B, load A, code.
// - Each set load bit copies the code into its channel register.
// - Each control bit acts on its own, so loads and shutdowns combine freely.
// - Reset clears the code registers, sets both shutdown states and holds both outputs at zero.
`timescale 1ns/1ps
`include "ddsl_map.svh"
module ddsl_loader
	import ddsl_pkg::*;
#(
	parameter int SETTLE_CYCLES = `DDSL_SETTLE_CYCLES
)
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic sclk_i,
	input wire logic select_n_i,
	input wire logic din_i,
	output ddsl_code_type channel_a_voltage_o,
	output ddsl_code_type channel_b_voltage_o,
	output ddsl_code_type stored_a_o,
	output ddsl_code_type stored_b_o,
	output logic shutdown_a_o,
	output logic shutdown_b_o,
	output logic ref_connect_a_o,
	output logic ref_connect_b_o,
	output logic settling_a_o,
	output logic settling_b_o,
	output logic command_done_o
);
	// ----------------------------------------
	// Link side and crossings
	// ----------------------------------------
	ddsl_word_type shift_w;
	ddsl_word_type shift_sync_w;
	logic edge_seen_w;
	logic toggle_sync_w;
	logic select_sync_w;
	ddsl_shifter u_shifter (
		.sclk_i(sclk_i),
		.select_n_i(select_n_i),
		.din_i(din_i),
		.shift_o(shift_w),
		.edge_seen_o(edge_seen_w)
	);
	// Reset values match the idle link, so no false select edge follows reset
	ddsl_sync #(
		.WIDTH(`DDSL_WORD_W + 2),
		.RESET_VAL({`DDSL_WORD_RESET, 1'b0, 1'b1})
	) u_sync (
		.clk_i(mclk_i),
		.reset_i(reset_i),
		.async_i({shift_w, edge_seen_w, select_n_i}),
		.sync_o({shift_sync_w, toggle_sync_w, select_sync_w})
	);
	// Word is stable once select is high, the shifter ignores the serial clock then
	logic select_prev_reg;
	logic rise_pend_reg;
	logic [1:0] hold_cnt_reg;
	logic hold_done_w;
	logic execute_w;
	assign hold_done_w = rise_pend_reg && (hold_cnt_reg == 2'h3);
	assign execute_w = hold_done_w && select_sync_w;
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			select_prev_reg <= 1'b1;
			rise_pend_reg <= 1'b0;
			hold_cnt_reg <= 2'h0;
		end
		else
		begin
			select_prev_reg <= select_sync_w;
			if (select_sync_w && !select_prev_reg)
			begin
				rise_pend_reg <= 1'b1;
				hold_cnt_reg <= 2'h0;
			end
			else if (hold_done_w || !select_sync_w)
				rise_pend_reg <= 1'b0;
			else if (rise_pend_reg)
				hold_cnt_reg <= hold_cnt_reg + 2'h1;
		end
	end
	// ----------------------------------------
	// Command decode, bit by bit
	// ----------------------------------------
	logic load_a_bit;
	logic load_b_bit;
	logic shutdown_a_bit;
	logic shutdown_b_bit;
	ddsl_code_type code_w;
	assign load_a_bit = shift_sync_w[`DDSL_BIT_LOAD_A];
	assign load_b_bit = shift_sync_w[`DDSL_BIT_LOAD_B];
	assign shutdown_a_bit = shift_sync_w[`DDSL_BIT_SHUTDOWN_A];
	assign shutdown_b_bit = shift_sync_w[`DDSL_BIT_SHUTDOWN_B];
	assign code_w = shift_sync_w[`DDSL_CODE_MSB:`DDSL_CODE_LSB];
	// ----------------------------------------
	// Channel registers and shutdown state
	// ----------------------------------------
	ddsl_code_type stored_a_reg;
	ddsl_code_type stored_b_reg;
	logic shutdown_a_reg;
	logic shutdown_b_reg;
	logic done_reg;
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			stored_a_reg <= `DDSL_CODE_RESET;
			stored_b_reg <= `DDSL_CODE_RESET;
			shutdown_a_reg <= 1'b1;
			shutdown_b_reg <= 1'b1;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= execute_w;
			if (execute_w)
			begin
				if (load_a_bit)
					stored_a_reg <= code_w;
				if (load_b_bit)
					stored_b_reg <= code_w;
				shutdown_a_reg <= shutdown_a_bit;
				shutdown_b_reg <= shutdown_b_bit;
			end
		end
	end
	// ----------------------------------------
	// Output state per channel
	// ----------------------------------------
	ddsl_out_state_type state_a_reg;
	ddsl_out_state_type state_b_reg;
	logic [31:0] settle_a_reg;
	logic [31:0] settle_b_reg;
	ddsl_code_type out_a_reg;
	ddsl_code_type out_b_reg;
	logic first_write_reg;
	function automatic ddsl_out_state_type next_state(
		input ddsl_out_state_type cur,
		input logic shut,
		input logic [31:0] cnt
	);
		ddsl_out_state_type nxt;
		nxt = cur;
		case (cur)
			DDSL_OUT_OFF: if (!shut) nxt = DDSL_OUT_SETTLING;
			DDSL_OUT_SETTLING:
				if (shut) nxt = DDSL_OUT_OFF;
				else if (cnt >= 32'(SETTLE_CYCLES - 1)) nxt = DDSL_OUT_ON;
			DDSL_OUT_ON: if (shut) nxt = DDSL_OUT_OFF;
			default: nxt = DDSL_OUT_OFF;
		endcase
		return nxt;
	endfunction : next_state
	ddsl_out_state_type state_a_next;
	ddsl_out_state_type state_b_next;
	logic live_a_w;
	logic live_b_w;
	assign state_a_next = next_state(state_a_reg, shutdown_a_reg || !first_write_reg, settle_a_reg);
	assign state_b_next = next_state(state_b_reg, shutdown_b_reg || !first_write_reg, settle_b_reg);
	assign live_a_w = (state_a_next != DDSL_OUT_OFF);
	assign live_b_w = (state_b_next != DDSL_OUT_OFF);
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			state_a_reg <= DDSL_OUT_OFF;
			state_b_reg <= DDSL_OUT_OFF;
			settle_a_reg <= 32'h0;
			settle_b_reg <= 32'h0;
			out_a_reg <= `DDSL_CODE_RESET;
			out_b_reg <= `DDSL_CODE_RESET;
			first_write_reg <= 1'b0;
		end
		else
		begin
			if (execute_w)
				first_write_reg <= 1'b1;
			state_a_reg <= state_a_next;
			state_b_reg <= state_b_next;
			settle_a_reg <= (state_a_next == DDSL_OUT_SETTLING) ? settle_a_reg + 32'h1 : 32'h0;
			settle_b_reg <= (state_b_next == DDSL_OUT_SETTLING) ? settle_b_reg + 32'h1 : 32'h0;
			out_a_reg <= live_a_w ? stored_a_reg : `DDSL_CODE_RESET;
			out_b_reg <= live_b_w ? stored_b_reg : `DDSL_CODE_RESET;
		end
	end
	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic ref_a_reg;
	logic ref_b_reg;
	logic settling_a_reg;
	logic settling_b_reg;
	always_ff @(posedge mclk_i)
	begin
		if (reset_i)
		begin
			ref_a_reg <= 1'b0;
			ref_b_reg <= 1'b0;
			settling_a_reg <= 1'b0;
			settling_b_reg <= 1'b0;
		end
		else
		begin
			ref_a_reg <= live_a_w;
			ref_b_reg <= live_b_w;
			settling_a_reg <= (state_a_next == DDSL_OUT_SETTLING);
			settling_b_reg <= (state_b_next == DDSL_OUT_SETTLING);
		end
	end
	assign channel_a_voltage_o = out_a_reg;
	assign channel_b_voltage_o = out_b_reg;
	assign stored_a_o = stored_a_reg;
	assign stored_b_o = stored_b_reg;
	assign shutdown_a_o = shutdown_a_reg;
	assign shutdown_b_o = shutdown_b_reg;
	assign ref_connect_a_o = ref_a_reg;
	assign ref_connect_b_o = ref_b_reg;
	assign settling_a_o = settling_a_reg;
	assign settling_b_o = settling_b_reg;
	assign command_done_o = done_reg;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_EXEC_TIMING: assert property (@(posedge mclk_i) disable iff (reset_i)
		$rose(select_sync_w) ##1 select_sync_w [*4] |=> command_done_o)
		else $error("command not executed five cycles after select rose");
	AST_DONE_PULSE: assert property (@(posedge mclk_i) disable iff (reset_i)
		command_done_o |=> !command_done_o)
		else $error("command done longer than one cycle");
	AST_DONE_CAUSE: assert property (@(posedge mclk_i) disable iff (reset_i)
		!execute_w |=> !command_done_o)
		else $error("command done without execution");
	AST_DROP: assert property (@(posedge mclk_i) disable iff (reset_i)
		rise_pend_reg && !select_sync_w |=> !command_done_o)
		else $error("command executed although select fell again");
	AST_WORD_STILL: assert property (@(posedge mclk_i) disable iff (reset_i)
		rise_pend_reg |-> $stable(toggle_sync_w) && $stable(shift_sync_w))
		else $error("shift word moved while select was high");
	AST_LOAD_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w && load_a_bit |=> stored_a_o == $past(code_w))
		else $error("channel A code not loaded");
	AST_LOAD_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w && load_b_bit |=> stored_b_o == $past(code_w))
		else $error("channel B code not loaded");
	AST_HOLD_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(execute_w && load_a_bit) |=> $stable(stored_a_o))
		else $error("channel A code changed without load");
	AST_HOLD_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		!(execute_w && load_b_bit) |=> $stable(stored_b_o))
		else $error("channel B code changed without load");
	AST_KEEP_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w && shutdown_a_bit && !load_a_bit |=> $stable(stored_a_o))
		else $error("channel A code lost in shutdown");
	AST_KEEP_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w && shutdown_b_bit && !load_b_bit |=> $stable(stored_b_o))
		else $error("channel B code lost in shutdown");
	AST_SHUT_FIELDS: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w |=> shutdown_a_o == $past(shift_sync_w[11])
		&& shutdown_b_o == $past(shift_sync_w[12]))
		else $error("shutdown state not taken from command");
	AST_SHUT_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
		shutdown_a_o ##1 shutdown_a_o |=> channel_a_voltage_o == 8'h00)
		else $error("channel A output not zero in shutdown");
	AST_SHUT_ZERO_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		shutdown_b_o ##1 shutdown_b_o |=> channel_b_voltage_o == 8'h00)
		else $error("channel B output not zero in shutdown");
	AST_FOLLOW_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		live_a_w |=> channel_a_voltage_o == $past(stored_a_o))
		else $error("channel A output does not show its stored code");
	AST_FOLLOW_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		live_b_w |=> channel_b_voltage_o == $past(stored_b_o))
		else $error("channel B output does not show its stored code");
	AST_QUIET_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		!first_write_reg |-> channel_a_voltage_o == 8'h00 && !ref_connect_a_o)
		else $error("channel A active before the first write");
	AST_QUIET_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		!first_write_reg |-> channel_b_voltage_o == 8'h00 && !ref_connect_b_o)
		else $error("channel B active before the first write");
	AST_REF_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
		shutdown_b_o ##1 shutdown_b_o |=> !ref_connect_b_o)
		else $error("reference still connected in shutdown");
	AST_REF_OFF_A: assert property (@(posedge mclk_i) disable iff (reset_i)
		shutdown_a_o ##1 shutdown_a_o |=> !ref_connect_a_o)
		else $error("channel A reference still connected in shutdown");
	AST_SETTLE: assert property (@(posedge mclk_i) disable iff (reset_i)
		$rose(settling_a_o) |-> settling_a_o [*8])
		else $error("settling ended too early");
	AST_SETTLE_B: assert property (@(posedge mclk_i) disable iff (reset_i)
		$rose(settling_b_o) |-> settling_b_o [*8])
		else $error("channel B settling ended too early");
	AST_SAME_CODE: assert property (@(posedge mclk_i) disable iff (reset_i)
		execute_w && load_a_bit && load_b_bit |=> stored_a_o == stored_b_o)
		else $error("both channels loaded with different codes");
endmodule : ddsl_loader

// *** dv/ddsl_host.sv ***
// Host model of the three-wire link: framed serial clock at 30 ns, select, data.
// Assumes the loader samples data on rising serial clock edges while select is low.
`timescale 1ns/1ps
module ddsl_host (
	output logic sclk_o,
	output logic select_n_o,
	output logic din_o
);
	// ----------------------------------------
	// Frame and stray-clock tasks
	// ----------------------------------------
	initial
	begin
		sclk_o = 1'b0;
		select_n_o = 1'b1;
		din_o = 1'b0;
	end
	// Sends the low n bits of w, top bit first, pausing after gap_at bits
	task automatic frame(input logic [31:0] w, input int n, input int gap_at);
		#67;
		select_n_o = 1'b0;
		#60;
		for (int i = n - 1; i >= 0; i--)
		begin
			din_o = w[i];
			#15;
			sclk_o = 1'b1;
			#15;
			sclk_o = 1'b0;
			if (n - i == gap_at)
				#200;
		end
		#45;
		select_n_o = 1'b1;
		din_o = ~din_o;
	endtask : frame
	// Serial clock pulses while deselected, data changing every cycle
	task automatic stray(input int n);
		repeat (n)
		begin
			din_o = ~din_o;
			#15;
			sclk_o = 1'b1;
			#15;
			sclk_o = 1'b0;
		end
	endtask : stray
endmodule : ddsl_host

// *** dv/ddsl_loader_bench.sv ***
// Self-checking bench of the dual converter loader, driven by the host model.
// Assumes ddsl_pkg is compiled first; the settling count is shortened.
`timescale 1ns/1ps
module ddsl_loader_bench;
	import ddsl_pkg::*;
	// ----------------------------------------
	// Clock, design and host
	// ----------------------------------------
	localparam int SETTLE = 10;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic sclk, sel_n, din, done, shd_a, shd_b, ref_a, ref_b, set_a, set_b;
	ddsl_code_type v_a, v_b, s_a, s_b;
	int n_errors = 0;
	int compares = 0;
	always #2 mclk_i = ~mclk_i;
	ddsl_host host (.sclk_o(sclk), .select_n_o(sel_n), .din_o(din));
	ddsl_loader #(.SETTLE_CYCLES(SETTLE)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
		.sclk_i(sclk), .select_n_i(sel_n), .din_i(din), .channel_a_voltage_o(v_a),
		.channel_b_voltage_o(v_b), .stored_a_o(s_a), .stored_b_o(s_b),
		.shutdown_a_o(shd_a), .shutdown_b_o(shd_b), .ref_connect_a_o(ref_a),
		.ref_connect_b_o(ref_b), .settling_a_o(set_a), .settling_b_o(set_b),
		.command_done_o(done));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim;
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic send(input logic [31:0] w, input int n, input int gap_at);
		int k;
		host.frame(w, n, gap_at);
		for (k = 0; k < 40 && done !== 1'b1; k++)
			@(negedge mclk_i);
		if (k == 40)
		begin
			n_errors++;
			$display("[FAIL] command_done expected 1 seen timeout");
			end_sim();
		end
		@(negedge mclk_i);
		check("done_pulse", {7'h00, done}, 8'h00);
		@(negedge mclk_i);
	endtask : send
	task automatic expect_state(input ddsl_code_type va, vb, sa, sb, input logic da, db);
		check("voltage_a", v_a, va);
		check("voltage_b", v_b, vb);
		check("stored_a", s_a, sa);
		check("stored_b", s_b, sb);
		check("shutdown_a", {7'h00, shd_a}, {7'h00, da});
		check("shutdown_b", {7'h00, shd_b}, {7'h00, db});
		check("ref_a", {7'h00, ref_a}, {7'h00, ~da});
		check("ref_b", {7'h00, ref_b}, {7'h00, ~db});
	endtask : expect_state
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		int seen;
		repeat (20) @(negedge mclk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		expect_state(8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
		$display("test reset finished");
		send(32'h0000_2380, 16, 0);
		expect_state(8'h80, 8'h80, 8'h80, 8'h80, 1'b0, 1'b0);
		check("settling_a", {7'h00, set_a}, 8'h01);
		repeat (SETTLE + 2) @(negedge mclk_i);
		check("settling_a", {7'h00, set_a}, 8'h00);
		$display("test load both finished");
		send(32'h0000_215A, 16, 8);
		expect_state(8'h5A, 8'h80, 8'h5A, 8'h80, 1'b0, 1'b0);
		$display("test split load finished");
		send(32'h0000_1233, 16, 0);
		expect_state(8'h5A, 8'h00, 8'h5A, 8'h33, 1'b0, 1'b1);
		$display("test shutdown with load finished");
		send(32'h0000_0000, 16, 0);
		expect_state(8'h5A, 8'h33, 8'h5A, 8'h33, 1'b0, 1'b0);
		check("settling_b", {7'h00, set_b}, 8'h01);
		check("settling_a", {7'h00, set_a}, 8'h00);
		$display("test wake finished");
		send(32'h000F_0BC3, 20, 0);
		expect_state(8'h00, 8'hC3, 8'hC3, 8'hC3, 1'b1, 1'b0);
		$display("test long frame finished");
		seen = 0;
		fork
			host.stray(4);
			repeat (40)
			begin
				@(negedge mclk_i);
				if (done === 1'b1)
					seen = 1;
			end
		join
		check("stray_done", seen[7:0], 8'h00);
		expect_state(8'h00, 8'hC3, 8'hC3, 8'hC3, 1'b1, 1'b0);
		$display("test deselected clock finished");
		reset_i = 1'b1;
		repeat (20) @(negedge mclk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		expect_state(8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
		send(32'h0000_2000, 16, 0);
		expect_state(8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
		$display("test second reset finished");
		end_sim();
	end
endmodule : ddsl_loader_bench
